/* File: bench/tach_host_model.sv */
// Host model that sends command bytes and collects response bytes.
`timescale 1ns/1ps
module tach_host_model (
  input  wire logic       clk,      // System clock.
  output logic [7:0]      rx_data,  // Command byte.
  output logic            rx_valid, // Command byte offered.
  input  wire logic       rx_ready, // Command byte taken.
  input  wire logic [7:0] tx_data,  // Response byte.
  input  wire logic       tx_valid, // Response byte offered.
  output logic            tx_ready  // Response byte taken.
);
  logic [7:0]  got_q[$];
  int unsigned cyc = 0;
  int unsigned stuck = 0;
  initial begin
    rx_data = 8'hA5;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // The host stalls every third cycle so the response buffer must hold words.
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got_q.push_back(tx_data);
    cyc <= cyc + 1;
    tx_ready <= #1 (cyc % 3 != 0);
  end
  // One byte is held until taken; the idle line then shows a different value.
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    rx_data = b;
    rx_valid = 1'b1;
    while (rx_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 50) stuck++;
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_data = ~b;
  endtask : send
endmodule : tach_host_model

/* File: bench/tach_props.sv */
// Port assertions for the touch application command handler.
`timescale 1ns/1ps
module tach_props (
  input wire logic       CLK,            // System clock.
  input wire logic       RST_N,          // Synchronous reset, active low.
  input wire logic [7:0] TX_DATA,        // Response byte.
  input wire logic       TX_VALID,       // Response byte offered.
  input wire logic       TX_READY,       // Response byte taken.
  input wire logic       BASELINE_PULSE, // Baseline refresh strobe.
  input wire logic       BOOT_MODE,      // Bootloader selected.
  input wire logic       MEM_REQ,        // Memory read request.
  input wire logic [7:0] GP_DATA,        // Gesture byte.
  input wire logic       GP_VALID,       // Gesture byte offered.
  input wire logic       GP_READY,       // Gesture byte taken.
  input wire logic       PREG_WE         // Register write strobe.
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Strobes last one cycle, so a consumer never acts twice on one command.
  AST_BASE_ACK: assert property (BASELINE_PULSE |-> ##[1:20] (TX_VALID && TX_DATA == 8'h02))
    else $error("no acknowledge after baseline refresh");
  AST_WE_ONE: assert property (PREG_WE |=> !PREG_WE)
    else $error("register write strobe too long");
  AST_WE_ACK: assert property (PREG_WE |-> ##[1:20] (TX_VALID && TX_DATA == 8'h02))
    else $error("no acknowledge after register write");
  AST_MEM_ONE: assert property (MEM_REQ |=> !MEM_REQ)
    else $error("memory request too long");
  // A stalled word must not change, or the host would lose a byte.
  AST_TX_HOLD: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("response byte changed while stalled");
  AST_GP_HOLD: assert property (GP_VALID && !GP_READY |=> GP_VALID && $stable(GP_DATA))
    else $error("gesture byte changed while stalled");
  AST_BOOT_STAY: assert property (BOOT_MODE |=> BOOT_MODE)
    else $error("bootloader selection dropped");
  AST_GP_FIRST: assert property (GP_VALID |-> !TX_VALID)
    else $error("reply started before payload was forwarded");
endmodule : tach_props

bind tach_top tach_props u_props (.CLK(CLK), .RST_N(RST_N), .TX_DATA(TX_DATA),
  .TX_VALID(TX_VALID), .TX_READY(TX_READY), .BASELINE_PULSE(BASELINE_PULSE),
  .BOOT_MODE(BOOT_MODE), .MEM_REQ(MEM_REQ), .GP_DATA(GP_DATA), .GP_VALID(GP_VALID),
  .GP_READY(GP_READY), .PREG_WE(PREG_WE));

/* File: bench/test_tach_top.sv */
// Self-checking testbench for the touch application command handler.
`timescale 1ns/1ps
module test_tach_top;
  logic        CLK = 1'b0, RST_N = 1'b0, BASELINE_PULSE, BOOT_MODE, MEM_REQ, PREG_WE;
  logic        RX_VALID, RX_READY, TX_VALID, TX_READY, GP_VALID, GP_READY = 1'b0;
  logic        MEM_ACK = 1'b0;
  logic [7:0]  RX_DATA, TX_DATA, GP_DATA, VER_DATA, MEM_DATA = 8'h00;
  logic [6:0]  VER_INDEX;
  logic [15:0] PREG_ADDR, we_a;
  logic [31:0] MEM_ADDR, PREG_WDATA, PREG_RDATA, ma = 0, we_d;
  logic [1:0]  mw = 0;
  logic [7:0]  gp_q[$], none_q[$];
  int          num_errors = 0, n_tests = 0, bl_n = 0, we_n = 0;

  always #2.5 CLK = ~CLK;

  tach_top dut (.CLK(CLK), .RST_N(RST_N), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
    .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .BASELINE_PULSE(BASELINE_PULSE), .BOOT_MODE(BOOT_MODE), .MEM_ADDR(MEM_ADDR),
    .MEM_REQ(MEM_REQ), .MEM_DATA(MEM_DATA), .MEM_ACK(MEM_ACK), .VER_DATA(VER_DATA),
    .VER_INDEX(VER_INDEX), .GP_DATA(GP_DATA), .GP_VALID(GP_VALID), .GP_READY(GP_READY),
    .PREG_ADDR(PREG_ADDR), .PREG_WDATA(PREG_WDATA), .PREG_WE(PREG_WE),
    .PREG_RDATA(PREG_RDATA));
  tach_host_model host (.clk(CLK), .rx_data(RX_DATA), .rx_valid(RX_VALID),
    .rx_ready(RX_READY), .tx_data(TX_DATA), .tx_valid(TX_VALID), .tx_ready(TX_READY));

  function automatic logic [7:0] fm(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : fm
  // Version and register sources are combinational, derived from the index and address.
  assign VER_DATA = {1'b0, VER_INDEX} ^ 8'h96;
  assign PREG_RDATA = {PREG_ADDR, ~PREG_ADDR};
  // Memory answers three cycles after a request; the gesture sink stalls every other cycle.
  always @(posedge CLK) begin
    MEM_ACK <= #1 (mw == 2'h1);
    MEM_DATA <= #1 fm(ma);
    if (MEM_REQ) begin
      ma <= MEM_ADDR;
      mw <= 2'h2;
    end else if (mw != 2'h0) mw <= mw - 2'h1;
    GP_READY <= #1 ~GP_READY;
    if (GP_VALID && GP_READY) gp_q.push_back(GP_DATA);
    if (BASELINE_PULSE) bl_n++;
    if (PREG_WE) begin
      we_n++;
      we_a = PREG_ADDR;
      we_d = PREG_WDATA;
    end
  end

  task automatic complete_run;
    $display("Errors %0d, comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic fail(input string m);
    num_errors++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask : fail
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) fail($sformatf("byte %h expected %h", g, e));
  endtask : chk8
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) fail($sformatf("word %h expected %h", g, e));
  endtask : chk32
  // Sends one packet, waits for the reply bytes and checks that nothing extra follows.
  task automatic xfer(input logic [7:0] cmd[$], input logic [7:0] exp[$]);
    int n;
    n = 0;
    host.got_q.delete();
    foreach (cmd[i]) host.send(cmd[i]);
    if (host.stuck != 0) begin
      fail("command byte not taken");
      complete_run();
    end
    while (host.got_q.size() < exp.size() && n < 2000) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 2000) begin
      fail("reply timeout");
      complete_run();
    end else begin
      repeat (20) @(posedge CLK);
      chk32(host.got_q.size(), exp.size());
      foreach (exp[i]) if (i < host.got_q.size()) chk8(host.got_q[i], exp[i]);
    end
  endtask : xfer

  task automatic t_base;
    int b0;
    b0 = bl_n;
    xfer('{8'h01, 8'hFB}, '{8'h02, 8'hF0, 8'hFB});
    chk32(bl_n - b0, 1);
  endtask : t_base
  task automatic t_ver;
    logic [7:0] e[$];
    e.push_back(8'h80);
    for (int i = 0; i < 128; i++) e.push_back(8'(i) ^ 8'h96);
    e = {e, 8'h02, 8'hF0, 8'hFF};
    xfer('{8'h01, 8'hFF}, e);
  endtask : t_ver
  // The block crosses a 256-byte boundary to catch a carry that is lost.
  task automatic t_read;
    xfer('{8'h07, 8'h17, 8'hFE, 8'h10, 8'h00, 8'h00, 8'h03, 8'h00},
         '{8'h04, 8'h17, fm(32'h10FE), fm(32'h10FF), fm(32'h1100),
           8'h02, 8'hF0, 8'h17});
  endtask : t_read
  task automatic t_set;
    logic [31:0] m[2];
    int w0;
    m = '{32'hFFFFFFFF, 32'h00FF0FF0};
    foreach (m[k]) begin
      w0 = we_n;
      xfer('{8'h0B, 8'hE0, 8'h04, 8'h00, 8'hDD, 8'hCC, 8'hBB, 8'hAA,
             m[k][7:0], m[k][15:8], m[k][23:16], m[k][31:24]},
           '{8'h02, 8'hF0, 8'hE0});
      chk32(we_n - w0, 1);
      chk32({16'h0000, we_a}, 32'h0004);
      chk32(we_d, (32'h0004FFFB & ~m[k]) | (32'hAABBCCDD & m[k]));
    end
  endtask : t_set
  task automatic t_pass;
    gp_q.delete();
    xfer('{8'h04, 8'hFC, 8'h11, 8'h22, 8'h33}, '{8'h01, 8'hF0});
    chk32(gp_q.size(), 3);
    foreach (gp_q[i]) chk8(gp_q[i], 8'(8'h11 * (i + 1)));
  endtask : t_pass
  // A zero count and an unknown identifier draw no reply and must not upset framing.
  task automatic t_bad;
    xfer('{8'h00}, none_q);
    xfer('{8'h02, 8'h33, 8'hAA}, none_q);
  endtask : t_bad
  task automatic t_boot;
    chk32(BOOT_MODE, 0);
    xfer('{8'h01, 8'h55}, '{8'h02, 8'hF0, 8'h55});
    chk32(BOOT_MODE, 1);
  endtask : t_boot
  // A reset in mid-run leaves bootloader operation and the parser must answer again.
  task automatic t_reset;
    @(posedge CLK);
    #1 RST_N = 1'b0;
    repeat (2) @(posedge CLK);
    #1 RST_N = 1'b1;
    chk32(BOOT_MODE, 0);
    t_base();
  endtask : t_reset

  initial begin
    repeat (6) @(posedge CLK);
    #1 RST_N = 1'b1;
    t_base();
    t_ver();
    t_read();
    t_set();
    t_pass();
    t_bad();
    t_base();
    t_boot();
    t_reset();
    complete_run();
  end
endmodule : test_tach_top

/* File: design/tach_skid.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module tach_skid_buf (
  input  wire logic       clk,      // System clock.
  input  wire logic       rst_n,    // Synchronous reset, active low.
  input  wire logic [7:0] in_data,  // Word from the source.
  input  wire logic       in_valid, // Source offers a word.
  output logic            in_ready, // Buffer has room.
  output logic [7:0]      out_data, // Word to the sink.
  output logic            out_valid,// Buffer holds a word.
  input  wire logic       out_ready // Sink takes the word.
);
  logic [7:0] mem_q [2];
  logic       rd_q;
  logic       wr_q;
  logic [1:0] cnt_q;
  logic       push;
  logic       pop;

  // Handshakes on each side.
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];

  // Storage is written only on push, so no reset is needed for data.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and occupancy; full stalls the source.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : tach_skid_buf

/* File: design/tach_top.sv */
// Application command interpreter for a touch controller.
`timescale 1ns/1ps
`include "tach_cfg.svh"

module tach_top
  import tach_pkg::*;
(
  input  wire logic        CLK,           // 200 MHz system clock.
  input  wire logic        RST_N,         // Synchronous reset, active low.
  input  wire logic [7:0]  RX_DATA,       // Command byte from host.
  input  wire logic        RX_VALID,      // Command byte offered.
  output logic             RX_READY,      // Command byte accepted.
  output logic [7:0]       TX_DATA,       // Response byte to host.
  output logic             TX_VALID,      // Response byte offered.
  input  wire logic        TX_READY,      // Host takes response byte.
  output logic             BASELINE_PULSE,// Refresh baseline, one cycle.
  output logic             BOOT_MODE,     // Bootloader operation selected.
  output logic [31:0]      MEM_ADDR,      // Memory read address.
  output logic             MEM_REQ,       // Memory read request, one cycle.
  input  wire logic [7:0]  MEM_DATA,      // Memory byte, valid with MEM_ACK.
  input  wire logic        MEM_ACK,       // Memory byte returned.
  input  wire logic [7:0]  VER_DATA,      // Version byte at VER_INDEX.
  output logic [6:0]       VER_INDEX,     // Version byte index.
  output logic [7:0]       GP_DATA,       // Byte to gesture controller.
  output logic             GP_VALID,      // Gesture byte offered.
  input  wire logic        GP_READY,      // Gesture controller takes byte.
  output logic [15:0]      PREG_ADDR,     // Parameter register address.
  output logic [31:0]      PREG_WDATA,    // Merged register value.
  output logic             PREG_WE,       // Register write, one cycle.
  input  wire logic [31:0] PREG_RDATA     // Current register value.
);
  tach_state_type state_q;
  logic [7:0]  cnt_q;       // Bytes following the current field.
  logic [7:0]  cmd_q;
  logic [3:0]  arg_q;
  logic [7:0]  args_q [10];
  logic [15:0] left_q;
  logic [31:0] addr_q;
  logic [7:0]  tx_d;
  logic        tx_v;
  logic        tx_rdy;
  logic        rx_take;
  logic        tx_fire;
  logic        mem_pend_q;
  logic        waiting_q;
  logic [7:0]  mem_byte_q;
  logic [31:0] val_w;
  logic [31:0] mask_w;

  // Data words leave through a two-entry buffer, so a host stall loses nothing.
  tach_skid_buf u_buf (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_data   (tx_d),
    .in_valid  (tx_v),
    .in_ready  (tx_rdy),
    .out_data  (TX_DATA),
    .out_valid (TX_VALID),
    .out_ready (TX_READY)
  );

  assign tx_fire = tx_v && tx_rdy;
  assign rx_take = RX_VALID && RX_READY;
  assign val_w   = {args_q[5], args_q[4], args_q[3], args_q[2]};
  assign mask_w  = {args_q[9], args_q[8], args_q[7], args_q[6]};

  // Response byte source; the buffer head and pass-through are separate paths.
  always_comb begin
    tx_v = 1'b0;
    tx_d = 8'h00;
    unique case (state_q)
      ST_DHDR_CNT: begin
        tx_v = 1'b1;
        tx_d = (cmd_q == `TACH_ID_VERSION) ? `TACH_CNT_VERSION : (left_q[7:0] + 8'h01);
      end
      ST_DHDR_ID: begin
        tx_v = (cmd_q == `TACH_ID_READ);
        tx_d = `TACH_ID_READ;
      end
      ST_DATA: begin
        tx_v = (cmd_q == `TACH_ID_VERSION) || mem_pend_q;
        tx_d = (cmd_q == `TACH_ID_VERSION) ? VER_DATA : mem_byte_q;
      end
      ST_ACK_CNT: begin
        // The last forwarded byte must leave before the reply starts.
        tx_v = !GP_VALID;
        // A pass-through reply carries only F0, so its count is one.
        tx_d = (cmd_q == `TACH_ID_PASS) ? `TACH_CNT_SHORT : `TACH_CNT_ACK;
      end
      ST_ACK_ID: begin
        tx_v = 1'b1;
        tx_d = `TACH_ID_ACK;
      end
      ST_ACK_ECHO: begin
        tx_v = (cmd_q != `TACH_ID_PASS);
        tx_d = cmd_q;
      end
      default: begin
        tx_v = 1'b0;
        tx_d = 8'h00;
      end
    endcase
  end

  // Command bytes are taken while parsing, or when forwarding and the gesture side has room.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RX_READY <= 1'b0;
    end else begin
      RX_READY <= ((state_q == ST_COUNT) || (state_q == ST_ID) || (state_q == ST_ARGS) ||
                   (state_q == ST_DRAIN) || ((state_q == ST_PASS) && !GP_VALID))
                  && !rx_take;
    end
  end

  // Main sequencer.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= ST_COUNT;
      cnt_q   <= 8'h00;
      cmd_q   <= 8'h00;
      arg_q   <= 4'h0;
      left_q  <= 16'h0000;
      addr_q  <= 32'h00000000;
    end else begin
      unique case (state_q)
        ST_COUNT: begin
          if (rx_take && RX_DATA != 8'h00) begin
            cnt_q   <= RX_DATA - 8'h01;
            state_q <= ST_ID;
          end
        end
        ST_ID: begin
          if (rx_take) begin
            cmd_q <= RX_DATA;
            arg_q <= 4'h0;
            if (RX_DATA == `TACH_ID_PASS) begin
              state_q <= (cnt_q == 8'h00) ? ST_ACK_CNT : ST_PASS;
            end else if ((RX_DATA == `TACH_ID_READ && cnt_q == `TACH_CNT_READ - 8'h01) ||
                         (RX_DATA == `TACH_ID_SETREG && cnt_q == `TACH_CNT_SETREG - 8'h01)) begin
              state_q <= ST_ARGS;
            end else if (cnt_q == 8'h00 && (RX_DATA == `TACH_ID_BASELINE ||
                         RX_DATA == `TACH_ID_VERSION || RX_DATA == `TACH_ID_BOOT)) begin
              state_q <= ST_EXEC;
            end else begin
              // Unknown or malformed commands are swallowed without a reply.
              state_q <= (cnt_q == 8'h00) ? ST_COUNT : ST_DRAIN;
            end
          end
        end
        ST_ARGS: begin
          if (rx_take) begin
            arg_q <= arg_q + 4'h1;
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
              state_q <= ST_EXEC;
            end
          end
        end
        ST_PASS: begin
          if (rx_take) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
              state_q <= ST_ACK_CNT;
            end
          end
        end
        ST_DRAIN: begin
          if (rx_take) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
              state_q <= ST_COUNT;
            end
          end
        end
        ST_EXEC: begin
          if (cmd_q == `TACH_ID_VERSION) begin
            left_q  <= {8'h00, `TACH_VERSION_BYTES};
            state_q <= ST_DHDR_CNT;
          end else if (cmd_q == `TACH_ID_READ) begin
            left_q  <= {args_q[`TACH_ARG_SIZE0 + 4'h1], args_q[`TACH_ARG_SIZE0]};
            addr_q  <= {args_q[3], args_q[2], args_q[1], args_q[`TACH_ARG_ADDR0]};
            state_q <= ST_DHDR_CNT;
          end else begin
            state_q <= ST_ACK_CNT;
          end
        end
        ST_DHDR_CNT: begin
          if (tx_fire) begin
            state_q <= (cmd_q == `TACH_ID_READ) ? ST_DHDR_ID : ST_DATA;
          end
        end
        ST_DHDR_ID: begin
          if (tx_fire) begin
            state_q <= (left_q == 16'h0000) ? ST_ACK_CNT : ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_fire) begin
            left_q <= left_q - 16'h0001;
            addr_q <= addr_q + 32'h00000001;
            if (left_q == 16'h0001) begin
              state_q <= ST_ACK_CNT;
            end
          end
        end
        ST_ACK_CNT: begin
          if (tx_fire) begin
            state_q <= ST_ACK_ID;
          end
        end
        ST_ACK_ID: begin
          if (tx_fire) begin
            state_q <= ST_ACK_ECHO;
          end
        end
        ST_ACK_ECHO: begin
          // Pass-through replies carry no echoed identifier.
          if (tx_fire || cmd_q == `TACH_ID_PASS) begin
            state_q <= ST_COUNT;
          end
        end
        default: begin
          state_q <= ST_COUNT;
        end
      endcase
    end
  end

  // Argument capture, least significant byte first.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < 10; i++) begin
        args_q[i] <= 8'h00;
      end
    end else if (state_q == ST_ARGS && rx_take) begin
      args_q[arg_q] <= RX_DATA;
    end
  end

  // Memory fetch: one outstanding byte, requested while the buffer slot is free.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      MEM_REQ    <= 1'b0;
      MEM_ADDR   <= 32'h00000000;
      mem_pend_q <= 1'b0;
      mem_byte_q <= 8'h00;
    end else begin
      MEM_REQ  <= (state_q == ST_DATA) && (cmd_q == `TACH_ID_READ) && !mem_pend_q &&
                  !MEM_REQ && !waiting_q;
      MEM_ADDR <= addr_q;
      if (MEM_ACK) begin
        mem_byte_q <= MEM_DATA;
        mem_pend_q <= 1'b1;
      end else if (tx_fire && state_q == ST_DATA) begin
        mem_pend_q <= 1'b0;
      end
    end
  end

  // Tracks a read in flight so that only one request is outstanding.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      waiting_q <= 1'b0;
    end else if (MEM_REQ) begin
      waiting_q <= 1'b1;
    end else if (MEM_ACK) begin
      waiting_q <= 1'b0;
    end
  end

  // Version bytes are indexed by how many have been sent, the total less those that remain.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      VER_INDEX <= 7'h00;
    end else begin
      VER_INDEX <= 7'(`TACH_VERSION_BYTES - left_q[7:0]) + 7'(tx_fire && state_q == ST_DATA);
    end
  end

  // Gesture pass-through byte holder; it stalls the command side when full.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      GP_VALID <= 1'b0;
      GP_DATA  <= 8'h00;
    end else if (state_q == ST_PASS && rx_take) begin
      GP_VALID <= 1'b1;
      GP_DATA  <= RX_DATA;
    end else if (GP_READY) begin
      GP_VALID <= 1'b0;
    end
  end

  // Side effects of executed commands.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      BASELINE_PULSE <= 1'b0;
      BOOT_MODE      <= 1'b0;
      PREG_WE        <= 1'b0;
      PREG_ADDR      <= 16'h0000;
      PREG_WDATA     <= 32'h00000000;
    end else begin
      BASELINE_PULSE <= (state_q == ST_EXEC) && (cmd_q == `TACH_ID_BASELINE);
      // Bootloader takes over once the echo byte of its acknowledge enters the response buffer.
      if (state_q == ST_ACK_ECHO && tx_fire && cmd_q == `TACH_ID_BOOT) begin
        BOOT_MODE <= 1'b1;
      end
      PREG_WE    <= (state_q == ST_EXEC) && (cmd_q == `TACH_ID_SETREG);
      PREG_ADDR  <= {args_q[1], args_q[`TACH_ARG_ADDR0]};
      PREG_WDATA <= (PREG_RDATA & ~mask_w) | (val_w & mask_w);
    end
  end
endmodule : tach_top

/* File: inc/tach_cfg.svh */
// Constants for the touch application command handler.
`ifndef TACH_CFG_SVH
`define TACH_CFG_SVH
`define TACH_ID_ACK        8'hF0
`define TACH_ID_BASELINE   8'hFB
`define TACH_ID_VERSION    8'hFF
`define TACH_ID_READ       8'h17
`define TACH_ID_BOOT       8'h55
`define TACH_ID_PASS       8'hFC
`define TACH_ID_SETREG     8'hE0
`define TACH_CNT_SHORT     8'h01
`define TACH_CNT_ACK       8'h02
`define TACH_CNT_READ      8'h07
`define TACH_CNT_SETREG    8'h0B
`define TACH_CNT_VERSION   8'h80
`define TACH_VERSION_BYTES 8'h80
`define TACH_ARG_ADDR0     4'h0
`define TACH_ARG_VAL0      4'h2
`define TACH_ARG_MASK0     4'h6
`define TACH_ARG_SIZE0     4'h4
`endif

/* File: inc/tach_pkg.sv */
// Types shared by the touch application command handler.
package tach_pkg;
  typedef enum logic [3:0] {
    ST_COUNT, ST_ID, ST_ARGS, ST_PASS, ST_EXEC, ST_DHDR_CNT, ST_DHDR_ID,
    ST_DATA, ST_WAIT_MEM, ST_ACK_CNT, ST_ACK_ID, ST_ACK_ECHO, ST_DRAIN
  } tach_state_type;
endpackage : tach_pkg
